// ===== core/buf_err_defines.vh
// Purpose: Constants for the buffer timer and error flag logic.
// Assumes: 40 MHz system clock; one timer tick per microsecond.
// Notes: Register indices are serial-interface register numbers.
// Behaviour
// - Buffer turns itself off after the programmed timeout interval.
// - Command byte bit 5 starts the buffer for the programmed interval.
// - Asserting the external buffer trigger pin also starts the buffer.
// - Busy flag is high exactly while the buffer is active.
// - Separate overvoltage, amp clip, gain overload and clamp flags.
// - Detected errors stay in the error status register until the host clears them.
// - Unmasked error flags are ORed onto one error output pin.
// - Flags latch by default; latch disable makes them track live.
// - Every sensor waits out a programmed suppression delay first.
// - By default errors are not recorded while the buffer is busy.
// - Output gain selects unity or 1.375; unity after reset.
// - Output stage flag sets on rail clipping or overcurrent.
// - Input switches change only by host register writes.
// - Faults of an unused output still feed the output flag.
// - While buffer is active, buffer-path switches are forced by hardware.
`ifndef BUF_ERR_DEFINES_VH
`define BUF_ERR_DEFINES_VH
`define REG_BUFFER_TIMEOUT 4'h3
`define REG_ERROR_STATUS 4'h4
`define REG_SWITCH_CTRL 4'h6
`define REG_ERROR_CTRL 4'ha
`define REG_ERROR_SUPPRESSION_DELAY 4'hb
`define REG_OUTPUT_CTRL 4'hc
`define BUSY_BIT 7
`define OUT_BIT 4
`define CMD_BUF_BIT 5
`define CTRL_LATCH_DIS_BIT 0
`define CTRL_BUSY_ENABLE_BIT 1
`define TICK_NS 1000
`define CLK_NS 25
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define RST_TIMEOUT 8'h00
`define RST_DELAY 8'h00
`define RST_MASK 8'h00
`endif

// ===== core/buffer_error_ctrl.v
// Purpose: Timed input current buffer and latched error flag logic.
// Assumes: A serial front end delivers decoded register writes, reads and
//          command-byte strobes on the clk domain; sensors are asynchronous.
// Notes: Timer and suppression delays count in 1 us ticks.
//        The tick phase is free running, so a suppression delay may come up to
//        one tick short (program one more tick if that matters); the buffer timer runs up to one tick long.
//        Flag clears are ignored while the synchronised sensor is still active, so a
//        condition that is still present cannot be hidden by a clear.
`include "buf_err_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module buffer_error_ctrl (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   // Register access from the serial front end.
   input wire reg_wr,
   input wire reg_rd,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_r,
   // Command byte strobe.
   input wire cmd_strobe,
   input wire [7:0] cmd_byte,
   // Pins and raw sensors (asynchronous).
   input wire buffer_trigger_pin,
   input wire input_overvoltage_raw,
   input wire input_amp_clip_raw,
   input wire gain_overload_raw,
   input wire clamp_conduction_raw,
   input wire positive_output_clip_raw,
   input wire positive_output_ovc_raw,
   input wire negative_output_clip_raw,
   input wire negative_output_ovc_raw,
   // Analog controls.
   output reg buffer_enable_r,
   output reg [7:0] switch_ctrl_r,
   output reg gain_mult_r,
   output reg error_pin_r
);
   // Number of recorded error sources: four input-side flags and one
   // output-stage flag.
   localparam NS = 5;
   // Prescaler terminal count, cut to the counter width on purpose.
   localparam integer TICK_LAST_I = `TICK_CYCLES - 1;
   localparam [7:0] TICK_LAST = TICK_LAST_I[7:0];
   // Host-visible settings.
   reg [7:0] timeout_r;
   reg [7:0] delay_r;
   reg [7:0] sw_reg_r;
   reg [7:0] err_ctrl_r;
   // Recorded error flags, one bit per source.
   reg [NS-1:0] flags_r;
   // Microsecond prescaler and its one-cycle tick.
   reg [7:0] tick_cnt_r;
   reg tick_r;
   // Buffer interval counter, in ticks.
   reg [7:0] buf_cnt_r;
   // Trigger pin: two sync flops plus one for edge finding.
   reg [2:0] trig_sync_r;
   // Raw sensor vector and its two synchroniser stages.
   wire [NS-1:0] raw;
   reg [NS-1:0] s1_r;
   reg [NS-1:0] s2_r;
   // Sensor conditions that survived the delay and the busy mask.
   wire [NS-1:0] rec;
   wire trig_rise;
   wire buf_start;
   // Host clear requests and the flags that may actually be cleared.
   wire [NS-1:0] clr_req;
   wire [NS-1:0] clr_ok;
   // Busy suppresses recording unless the host allows it.
   wire busy_mask;
   // Flags routed to the error pin, and the composed read-back values.
   wire [NS-1:0] pin_src;
   wire [7:0] status_word;
   reg [7:0] rd_mux;
   // Output fault is the OR of both outputs, used or not.
   assign raw = {positive_output_clip_raw | positive_output_ovc_raw |
                 negative_output_clip_raw | negative_output_ovc_raw,
                 clamp_conduction_raw, gain_overload_raw,
                 input_amp_clip_raw, input_overvoltage_raw};
   // Pin and sensors cross in two flops; third flop is for edge finding.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trig_sync_r <= 3'h0;
         s1_r <= {NS{1'b0}};
         s2_r <= {NS{1'b0}};
      end else begin
         trig_sync_r <= {trig_sync_r[1:0], buffer_trigger_pin};
         s1_r <= raw;
         s2_r <= s1_r;
      end
   end
   assign trig_rise = trig_sync_r[1] & ~trig_sync_r[2];
   assign buf_start = trig_rise |
      (cmd_strobe & cmd_byte[`CMD_BUF_BIT]);
   // Microsecond tick prescaler. One shared tick keeps every delay in the
   // same unit, at the cost of up to one tick of phase error per start.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_r <= 8'h00;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == TICK_LAST) begin
         tick_cnt_r <= 8'h00;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 8'h01;
         tick_r <= 1'b0;
      end
   end
   // Buffer timer; a zero timeout still runs to the next tick so a start is seen.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         buffer_enable_r <= 1'b0;
         buf_cnt_r <= 8'h00;
      end else if (buf_start) begin
         buffer_enable_r <= 1'b1;
         buf_cnt_r <= 8'h00;
      end else if (buffer_enable_r && tick_r) begin
         if (buf_cnt_r >= timeout_r)
            buffer_enable_r <= 1'b0;
         else
            buf_cnt_r <= buf_cnt_r + 8'h01;
      end
   end
   // Switching transients during the buffer interval would flood the flags,
   // so recording is held off while busy unless the host allows it.
   assign busy_mask = buffer_enable_r & ~err_ctrl_r[`CTRL_BUSY_ENABLE_BIT];
   // Per-sensor suppression delay counters, one per flag.
   genvar g;
   generate
      for (g = 0; g < NS; g = g + 1) begin : sup
         reg [7:0] cnt_r;
         reg ok_r;
         always @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_r <= 8'h00;
               ok_r <= 1'b0;
            end else if (!s2_r[g]) begin
               cnt_r <= 8'h00;
               ok_r <= 1'b0;
            end else if (cnt_r >= delay_r) begin
               ok_r <= 1'b1;
            end else if (tick_r) begin
               cnt_r <= cnt_r + 8'h01;
            end
         end
         // A flag is only recorded once its delay has run out and the
         // busy mask lets it through.
         assign rec[g] = ok_r & ~busy_mask;
      end
   endgenerate
   // Host clear requests; a write of one asks for that flag to be cleared.
   assign clr_req = (reg_wr && reg_addr == `REG_ERROR_STATUS) ?
      reg_wdata[NS-1:0] : {NS{1'b0}};
   // A clear is honoured only where the synchronised condition has gone.
   assign clr_ok = clr_req & ~s2_r;
   // Flags: latch, or follow live when latch is disabled; set beats clear.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         flags_r <= {NS{1'b0}};
      else if (err_ctrl_r[`CTRL_LATCH_DIS_BIT])
         flags_r <= rec;
      else
         flags_r <= rec | (flags_r & ~clr_ok);
   end
   // Registers; switches change only by host write.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timeout_r <= `RST_TIMEOUT;
         delay_r <= `RST_DELAY;
         sw_reg_r <= 8'h00;
         err_ctrl_r <= `RST_MASK;
         gain_mult_r <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            `REG_BUFFER_TIMEOUT: timeout_r <= reg_wdata;
            `REG_ERROR_SUPPRESSION_DELAY: delay_r <= reg_wdata;
            `REG_SWITCH_CTRL: sw_reg_r <= reg_wdata;
            `REG_ERROR_CTRL: err_ctrl_r <= reg_wdata;
            `REG_OUTPUT_CTRL: gain_mult_r <= reg_wdata[0];
            default: ;
         endcase
      end
   end
   // Flags that the host routed to the error pin.
   assign pin_src = flags_r & err_ctrl_r[7:3];
   // Status word as the host sees it: busy on top, flags at the bottom.
   assign status_word = {buffer_enable_r, 2'h0, flags_r};
   // Read multiplexer; unmapped indices read as zero.
   always @* begin
      rd_mux = 8'h00;
      case (reg_addr)
         `REG_BUFFER_TIMEOUT: rd_mux = timeout_r;
         `REG_ERROR_STATUS: rd_mux = status_word;
         `REG_SWITCH_CTRL: rd_mux = sw_reg_r;
         `REG_ERROR_CTRL: rd_mux = err_ctrl_r;
         `REG_ERROR_SUPPRESSION_DELAY: rd_mux = delay_r;
         `REG_OUTPUT_CTRL: rd_mux = {7'h00, gain_mult_r};
         default: rd_mux = 8'h00;
      endcase
   end
   // Outputs: buffer forces the low nibble (buffer path switches).
   // Every output is a flop so the analog side never sees decode glitches.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         switch_ctrl_r <= 8'h00;
         error_pin_r <= 1'b0;
         reg_rdata_r <= 8'h00;
      end else begin
         switch_ctrl_r <= buffer_enable_r ? {sw_reg_r[7:4], 4'hf} :
            sw_reg_r;
         error_pin_r <= |pin_src;
         // Read data holds between reads, so a slow host may take its time.
         if (reg_rd)
            reg_rdata_r <= rd_mux;
      end
   end
endmodule // buffer_error_ctrl
`default_nettype wire

// ===== sim/reg_host.sv
// Purpose: Host model that reaches the block registers.
// Assumes: A request is taken on the first edge it is seen high.
// Notes: Released data shows the inverse, never the old value.
`timescale 1ns/100ps
`default_nettype none
module reg_host (
   // Clock.
   input wire logic clk,
   // Register strobes toward the block.
   output var logic reg_wr = 1'b0,
   output var logic reg_rd = 1'b0,
   output var logic [3:0] reg_addr = 4'h0,
   output var logic [7:0] reg_wdata = 8'h00,
   input wire logic [7:0] reg_rdata_r
);
   // One-cycle write; switches and flag clears only move this way.
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // Read data is taken just after the edge that accepts the strobe.
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_r;
   endtask
endmodule // reg_host
`default_nettype wire

// ===== sim/buffer_error_props.sv
// Purpose: Port checks for the buffer timer and error flags.
// Assumes: One 40 MHz domain, timer tick of 40 cycles.
// Notes: Bound to every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module buffer_error_props (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Requests seen by the block.
   input wire logic reg_wr,
   input wire logic [3:0] reg_addr,
   input wire logic cmd_strobe,
   input wire logic [7:0] cmd_byte,
   input wire logic buffer_trigger_pin,
   // Outputs.
   input wire logic [7:0] switch_ctrl_r,
   input wire logic buffer_enable_r,
   input wire logic gain_mult_r,
   input wire logic error_pin_r
);
   // Busy run since the last start; a restart request clears it, so the
   // cap bounds one programmed interval: 256 ticks plus slack.
   logic [13:0] run_r;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) run_r <= 14'h0;
      else if (!buffer_enable_r || buffer_trigger_pin ||
         (cmd_strobe && cmd_byte[5])) run_r <= 14'h0;
      else run_r <= run_r + 14'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_cmd;
      cmd_strobe && cmd_byte[5];
   endsequence
   a_cmd_start: assert property (s_cmd |=> buffer_enable_r)
      else $error("command did not start buffer");
   a_pin_start: assert property ($rose(buffer_trigger_pin)
      |-> ##[1:5] buffer_enable_r) else $error("pin did not start");
   a_busy_min: assert property ($rose(buffer_enable_r)
      |-> buffer_enable_r[*8]) else $error("busy too short");
   a_run_cap: assert property (run_r <= 14'h2840)
      else $error("buffer never timed out");
   a_sw_forced: assert property (buffer_enable_r
      |=> switch_ctrl_r[3:0] == 4'hf) else $error("switches not forced");
   a_sw_source: assert property ($changed(switch_ctrl_r)
      |-> $past(reg_wr && reg_addr == 4'h6, 2) ||
      ($past(buffer_enable_r) != $past(buffer_enable_r, 2)))
      else $error("switch moved without write");
   a_gain_src: assert property ($changed(gain_mult_r)
      |-> $past(reg_wr && reg_addr == 4'hc)) else $error("gain moved");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b
      |-> !(buffer_enable_r || gain_mult_r || error_pin_r))
      else $error("output active in reset");
endmodule // buffer_error_props
bind buffer_error_ctrl buffer_error_props props (.*);
`default_nettype wire

// ===== sim/buffer_error_ctrl_test.sv
// Purpose: Self-checking bench for the buffer and error block.
// Assumes: Timeout 2 gives a busy run of 81 to 120 cycles.
// Notes: Sensors fan out from one vector.
`timescale 1ns/100ps
`default_nettype none
module buffer_error_ctrl_test;
   logic clk = 0, rst_b = 1, cmd_strobe = 0, buffer_trigger_pin = 0;
   logic reg_wr, reg_rd, buffer_enable_r, gain_mult_r, error_pin_r;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_r, switch_ctrl_r, v, s = 0, cmd_byte = 0;
   int miscompares = 0, n_compared = 0, n;
   wire input_overvoltage_raw = s[0], input_amp_clip_raw = s[1];
   wire gain_overload_raw = s[2], clamp_conduction_raw = s[3];
   wire positive_output_clip_raw = s[4], positive_output_ovc_raw = s[5];
   wire negative_output_clip_raw = s[6], negative_output_ovc_raw = s[7];
   // Free-running 40 MHz clock.
   initial forever #12.5 clk = ~clk;
   reg_host host (.*);
   buffer_error_ctrl dut (.*);
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Counts busy cycles; a bound stops a buffer that never ends.
   task busy_len;
      for (n = 0; buffer_enable_r === 1'b1; n++) begin
         @(posedge clk);
         #1 if (n > 12000) begin
            miscompares++;
            finish_test;
         end
      end
   endtask
   task strobe;
      @(posedge clk);
      cmd_strobe <= 1'b1;
      cmd_byte <= 8'h20;
      @(posedge clk);
      cmd_strobe <= 1'b0;
   endtask
   task t_cmd;
      chk({7'h0, gain_mult_r}, 8'h00);
      host.wr(4'hc, 8'h01);
      host.wr(4'h5, 8'h77);
      host.rd(4'h5, v);
      chk(v, 8'h00);
      host.wr(4'h3, 8'h02);
      host.rd(4'h3, v);
      chk(v | {7'h0, gain_mult_r}, 8'h03);
      strobe;
      host.rd(4'h4, v);
      chk({v[7], 3'h0, switch_ctrl_r[3:0]}, 8'h8f);
      busy_len;
      chk({7'h0, n > 70 && n <= 120}, 8'h01);
   endtask
   // One 100 ns trigger pin pulse starts the buffer; a command restarts it.
   task t_pin;
      @(posedge clk);
      buffer_trigger_pin <= 1'b1;
      repeat (4) @(posedge clk);
      buffer_trigger_pin <= 1'b0;
      repeat (4) @(posedge clk);
      chk({7'h0, buffer_enable_r}, 8'h01);
      repeat (50) @(posedge clk);
      strobe;
      busy_len;
      chk({7'h0, n >= 75}, 8'h01);
   endtask
   task t_err;
      host.wr(4'hb, 8'h02);
      host.wr(4'ha, 8'h00);
      s <= 8'h02;
      repeat (20) @(posedge clk);
      s <= 8'h81;
      repeat (100) @(posedge clk);
      s <= 8'h00;
      host.rd(4'h4, v);
      chk(v, 8'h11);
      host.wr(4'h4, 8'h01);
      host.rd(4'h4, v);
      chk(v, 8'h10);
      host.wr(4'h4, 8'h10);
      host.wr(4'h3, 8'h04);
      strobe;
      s <= 8'h04;
      repeat (100) @(posedge clk);
      s <= 8'h00;
      busy_len;
      host.rd(4'h4, v);
      chk(v, 8'h00);
   endtask
   // Live flags, recording while busy, flag 0 routed to the error pin.
   task t_live;
      host.wr(4'ha, 8'h0b);
      strobe;
      s <= 8'h01;
      repeat (100) @(posedge clk);
      chk({7'h0, error_pin_r}, 8'h01);
      s <= 8'h00;
      host.rd(4'h4, v);
      chk(v, 8'h81);
      repeat (10) @(posedge clk);
      host.rd(4'h4, v);
      chk(v, 8'h80);
      chk({7'h0, error_pin_r}, 8'h00);
      busy_len;
   endtask
   initial begin
      rst_b <= 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      t_cmd;
      t_pin;
      t_err;
      t_live;
      finish_test;
   end
endmodule // buffer_error_ctrl_test
`default_nettype wire
